// [src/cbu_branch_unit.sv]
// Conditional branch unit with the and-not-immediate datapath.
// Behaviour
// [RULE1] And-not-immediate writes source A AND NOT extended immediate in one cycle.
// [RULE2] Immediate is sign-extended 16 bits, or prefix-high plus field when prefixed.
// [RULE3] Equal register form branches when A is zero, target PC plus B.
// [RULE4] Equal immediate form branches when A is zero, target PC plus immediate.
// [RULE5] Greater-or-equal register form branches when A at least zero, PC plus B.
// [RULE6] Greater-or-equal immediate form branches when A at least zero, PC plus immediate.
// [RULE7] Greater-than register form branches when A above zero, PC plus B.
// [RULE8] Greater-than immediate form branches when A above zero, PC plus immediate.
// [RULE9] Less-or-equal register form branches when A at most zero, PC plus B.
// [RULE10] Less-or-equal immediate form branches when A at most zero, PC plus immediate.
// [RULE11] Taken with delay flag lets the following instruction complete.
// [RULE12] Taken without delay flag kills the following instruction.
// [RULE13] Untaken branch advances PC by four regardless of delay flag.
// [RULE14] Untaken branch takes one cycle.
// [RULE15] Taken branch with delay flag takes two cycles.
// [RULE16] Taken branch without delay flag takes three cycles.
// [RULE17] Register form: delay at bit 6, A at 11, B at 16, bits 21-31 zero.
// [RULE18] Immediate form sets opcode bit 2, immediate in bits 16 to 31.
// [RULE19] Condition field bits 7-10: 0000 eq, 0011 le, 0100 gt, 0101 ge.
// [RULE20] Branches change only the PC, never registers or flags.
// [RULE21] Condition 0001 is not-equal, 0010 is less-than.
// [RULE22] Source A is compared as signed 32-bit two's complement.
// [RULE23] Targets are based on the branch instruction's own address.
`timescale 1ns/1ps
module cbu_branch_unit (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire cbu_pkg::cbu_issue_t issue,
    output logic issue_ready,
    output cbu_pkg::cbu_wb_t wb,
    output logic pc_load,
    output logic [31:0] pc_target,
    output logic kill_next,
    output logic busy,
    output logic illegal
);
    import cbu_pkg::*;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic [31:0] cbu_ext_imm(input logic [15:0] field, input logic pre_v,
                                                input logic [15:0] pre_hi);
        cbu_ext_imm = pre_v ? {pre_hi, field} : {{16{field[15]}}, field};
    endfunction : cbu_ext_imm

    wire logic [5:0] opc = issue.instr[OPC_HI:OPC_LO];
    wire logic [15:0] imm_field = issue.instr[IMM_HI:0];
    wire logic [3:0] cond = issue.instr[COND_HI:COND_LO]; // RULE19
    wire logic dly = issue.instr[DLY_BIT]; // RULE17
    wire logic is_reg_form = (opc == OPC_BRC_REG) && (issue.instr[PAD_HI:0] == REG_FORM_PAD); // RULE17
    wire logic is_imm_form = (opc == OPC_BRC_IMM); // RULE18
    wire logic is_andni = (opc == OPC_ANDNI);
    wire logic [31:0] imm_op = cbu_ext_imm(imm_field, issue.imm_prefix_valid, issue.imm_prefix_high); // RULE2
    wire logic [31:0] offset = is_imm_form ? imm_op : issue.src_second;
    wire logic [31:0] target = issue.pc + offset; // RULE23
    wire logic [31:0] seq_pc = issue.pc + PC_STEP; // RULE13
    wire logic cond_taken;
    wire logic cond_known;

    cbu_cond_eval u_cond (
        .cond(cond),
        .value(issue.src_first),
        .taken(cond_taken),
        .known(cond_known)
    );

    // RULE22: the evaluator reads bit 31 as the sign.
    wire logic accept = issue.valid && issue_ready;
    wire logic is_branch = (is_reg_form || is_imm_form) && cond_known;
    wire logic br_fire = accept && is_branch;
    wire logic br_taken = br_fire && cond_taken; // RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE21
    wire logic bad_instr = accept && !is_branch && !is_andni
                           && ((opc == OPC_BRC_REG) || is_imm_form);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // A taken branch holds the issue port for extra cycles; the slot
    // instruction runs in the first with the delay flag, so no flush there.
    cbu_state_t state_reg, state_next;
    logic [1:0] wait_reg, wait_next;

    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        case (state_reg)
            CBU_IDLE: begin
                if (br_taken && dly) begin
                    state_next = CBU_SLOT; // RULE11 RULE15
                    wait_next = LAT_TAKEN_DLY - LAT_NOT_TAKEN;
                end else if (br_taken) begin
                    state_next = CBU_FLUSH; // RULE12 RULE16
                    wait_next = LAT_TAKEN_NODLY - LAT_NOT_TAKEN;
                end
            end
            CBU_SLOT, CBU_FLUSH: begin
                wait_next = wait_reg - 2'h1;
                if (wait_reg == 2'h1) begin
                    state_next = CBU_IDLE;
                end
            end
            default: begin
                state_next = CBU_IDLE;
                wait_next = 2'h0;
            end
        endcase
    end

    wire logic ready_next = (state_next == CBU_IDLE); // RULE14
    wire logic kill_next_d = br_taken && !dly; // RULE12

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= CBU_IDLE;
            wait_reg <= 2'h0;
            issue_ready <= 1'b1;
            busy <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            issue_ready <= ready_next;
            busy <= !ready_next;
        end
    end

    // ------------------------------------------------------------------
    // Result outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb <= '0;
            pc_load <= 1'b0;
            pc_target <= ZERO_WORD;
            kill_next <= 1'b0;
            illegal <= 1'b0;
        end else begin
            wb.valid <= accept && is_andni; // RULE1 RULE20
            wb.dest <= issue.instr[RD_HI:RD_LO];
            wb.data <= issue.src_first & ~imm_op; // RULE1
            pc_load <= br_fire; // RULE20
            pc_target <= cond_taken ? target : seq_pc; // RULE13
            kill_next <= kill_next_d;
            illegal <= bad_instr;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    untaken_one_cycle_a: assert property (br_fire && !cond_taken |=> issue_ready && pc_load) // RULE14
        else $error("untaken branch did not finish in one cycle");
    untaken_seq_pc_a: assert property (br_fire && !cond_taken |=> pc_target == $past(issue.pc) + PC_STEP) // RULE13
        else $error("untaken branch target not pc plus four");
    taken_dly_two_a: assert property (br_taken && dly |=> !issue_ready ##1 issue_ready) // RULE15
        else $error("delayed taken branch latency wrong");
    taken_nodly_three_a: assert property (br_taken && !dly |=> !issue_ready [*2] ##1 issue_ready) // RULE16
        else $error("undelayed taken branch latency wrong");
    flush_no_delay_a: assert property (br_taken && !dly |=> kill_next) // RULE12
        else $error("following instruction not killed");
    slot_keeps_next_a: assert property (br_taken && dly |=> !kill_next) // RULE11
        else $error("delay slot instruction killed");
    taken_target_a: assert property (br_taken |=> pc_target == $past(target)) // RULE23
        else $error("taken target wrong");
    eq_taken_a: assert property (br_fire && cond == COND_EQ |-> cond_taken == (issue.src_first == ZERO_WORD)) // RULE3
        else $error("equal condition wrong");
    gt_signed_a: assert property (br_fire && cond == COND_GT && issue.src_first[31] |-> !cond_taken) // RULE22
        else $error("negative value taken as greater");
    ge_taken_a: assert property (br_fire && cond == COND_GE |-> cond_taken == !issue.src_first[31]) // RULE5
        else $error("greater-or-equal condition wrong");
    le_taken_a: assert property (br_fire && cond == COND_LE && issue.src_first == ZERO_WORD |-> cond_taken) // RULE9
        else $error("less-or-equal at zero not taken");
    branch_no_wb_a: assert property (br_fire |=> !wb.valid) // RULE20
        else $error("branch wrote a register");
    andni_result_a: assert property (accept && is_andni |=> wb.valid && wb.data == $past(issue.src_first & ~imm_op)) // RULE1
        else $error("and-not-immediate result wrong");

    taken_dly_c: cover property (br_taken && dly);
    taken_nodly_c: cover property (br_taken && !dly);
    untaken_c: cover property (br_fire && !cond_taken);
    andni_prefix_c: cover property (accept && is_andni && issue.imm_prefix_valid);
    illegal_c: cover property (bad_instr);

endmodule : cbu_branch_unit

// [src/cbu_cond_eval.sv]
// Condition test of source register A against zero.
`timescale 1ns/1ps
module cbu_cond_eval (
    input wire logic [3:0] cond,
    input wire logic [31:0] value,
    output logic taken,
    output logic known
);
    import cbu_pkg::*;

    wire is_zero = (value == ZERO_WORD);
    wire is_neg = value[XLEN-1];

    always_comb begin
        known = 1'b1;
        case (cond)
            COND_EQ: taken = is_zero;
            COND_NE: taken = !is_zero;
            COND_LT: taken = is_neg;
            COND_LE: taken = is_neg || is_zero;
            COND_GT: taken = !is_neg && !is_zero;
            COND_GE: taken = !is_neg;
            default: begin
                taken = 1'b0;
                known = 1'b0;
            end
        endcase
    end
endmodule : cbu_cond_eval

// [src/cbu_pkg.sv]
// Package for the conditional branch unit: encodings, field positions and types.
package cbu_pkg;

    // ------------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------------
    localparam int XLEN = 32;
    localparam logic [5:0] OPC_BRC_REG = 6'h27;
    localparam logic [5:0] OPC_BRC_IMM = 6'h2f;
    localparam logic [5:0] OPC_ANDNI = 6'h2b;
    localparam logic [3:0] COND_EQ = 4'h0;
    localparam logic [3:0] COND_NE = 4'h1;
    localparam logic [3:0] COND_LT = 4'h2;
    localparam logic [3:0] COND_LE = 4'h3;
    localparam logic [3:0] COND_GT = 4'h4;
    localparam logic [3:0] COND_GE = 4'h5;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [10:0] REG_FORM_PAD = 11'h000;

    // ------------------------------------------------------------------
    // Field positions, little-endian bit index (big-endian index 0 is bit 31)
    // ------------------------------------------------------------------
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int RD_HI = 25;
    localparam int RD_LO = 21;
    localparam int DLY_BIT = 25;
    localparam int COND_HI = 24;
    localparam int COND_LO = 21;
    localparam int RA_HI = 20;
    localparam int RA_LO = 16;
    localparam int RB_HI = 15;
    localparam int RB_LO = 11;
    localparam int PAD_HI = 10;
    localparam int IMM_HI = 15;

    // Latencies in cycles for each branch outcome.
    localparam logic [1:0] LAT_NOT_TAKEN = 2'h1;
    localparam logic [1:0] LAT_TAKEN_DLY = 2'h2;
    localparam logic [1:0] LAT_TAKEN_NODLY = 2'h3;

    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [31:0] pc;
        logic [31:0] src_first;
        logic [31:0] src_second;
        logic imm_prefix_valid;
        logic [15:0] imm_prefix_high;
    } cbu_issue_t;

    typedef struct packed {
        logic valid;
        logic [4:0] dest;
        logic [31:0] data;
    } cbu_wb_t;

    typedef enum logic [1:0] {
        CBU_IDLE,
        CBU_SLOT,
        CBU_FLUSH
    } cbu_state_t;

endpackage : cbu_pkg

// [test/cbu_fetch_model.sv]
// Fetch-side partner that offers instructions and operands to the branch unit.
`timescale 1ns/1ps
module cbu_fetch_model (
    input wire logic sys_clk,
    input wire logic issue_ready,
    output cbu_pkg::cbu_issue_t issue
);
    import cbu_pkg::*;
    initial begin
        issue = '0;
    end
    // Valid stays up on return, so back-to-back offers never touch it twice in one step.
    task automatic offer(input logic [31:0] instr, input logic [31:0] pc, input logic [31:0] a,
                         input logic [31:0] b, input logic pv, input logic [15:0] ph);
        logic r;
        #1;
        issue.valid = 1'b1;
        issue.instr = instr;
        issue.pc = pc;
        issue.src_first = a;
        issue.src_second = b;
        issue.imm_prefix_valid = pv;
        issue.imm_prefix_high = ph;
        r = 1'b0;
        while (r !== 1'b1) begin
            @(negedge sys_clk);
            r = issue_ready;
            @(posedge sys_clk);
        end
    endtask : offer
    // Released instruction, operand and prefix-high lines show inverted data, so a stale operand can never pass for a live one.
    task automatic release_bus();
        #1;
        issue.valid = 1'b0;
        issue.instr = ~issue.instr;
        issue.src_first = ~issue.src_first;
        issue.src_second = ~issue.src_second;
        issue.imm_prefix_high = ~issue.imm_prefix_high;
    endtask : release_bus
endmodule : cbu_fetch_model

// [test/tb_conditional_branch_unit.sv]
// Self-checking testbench for the conditional branch unit.
`timescale 1ns/1ps
module tb_conditional_branch_unit;
    import cbu_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    cbu_issue_t issue;
    cbu_wb_t wb;
    logic issue_ready, pc_load, kill_next, busy, illegal;
    logic [31:0] pc_target;
    logic [35:0] notes[$];
    logic [31:0] lfsr_state = 32'h0000_ba43;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #20 sys_clk = ~sys_clk;

    cbu_branch_unit i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .issue(issue), .issue_ready(issue_ready),
        .wb(wb), .pc_load(pc_load), .pc_target(pc_target), .kill_next(kill_next), .busy(busy),
        .illegal(illegal));
    cbu_fetch_model i_fetch (.sys_clk(sys_clk), .issue_ready(issue_ready), .issue(issue));

    function automatic void rnd(output logic [31:0] v);
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        v = lfsr_state;
    endfunction : rnd

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    function automatic logic cond_true(input logic [3:0] c, input logic [31:0] a);
        case (c)
            COND_EQ: return a == ZERO_WORD;
            COND_NE: return a != ZERO_WORD;
            COND_LT: return a[31];
            COND_LE: return a[31] || a == ZERO_WORD;
            COND_GT: return !a[31] && a != ZERO_WORD;
            default: return !a[31];
        endcase
    endfunction : cond_true

    task automatic branch(input logic imm_form, input logic dly, input logic [3:0] cond, input logic [31:0] a);
        logic [31:0] pc, b, off;
        logic tk;
        rnd(pc);
        rnd(b);
        pc[1:0] = 2'h0;
        off = imm_form ? {{16{b[15]}}, b[15:0]} : b;
        tk = cond_true(cond, a);
        notes.push_back({1'b0, tk & !dly, tk ? (dly ? 2'h1 : 2'h2) : 2'h0, tk ? pc + off : pc + PC_STEP});
        i_fetch.offer({imm_form ? OPC_BRC_IMM : OPC_BRC_REG, dly, cond, 5'h03,
            imm_form ? b[15:0] : {5'h04, REG_FORM_PAD}}, pc, a, b, 1'b0, 16'h0000);
    endtask : branch

    task automatic andni(input logic pv);
        logic [31:0] a, r, imm;
        rnd(a);
        rnd(r);
        imm = pv ? r : {{16{r[15]}}, r[15:0]};
        notes.push_back({1'b1, 3'h0, a & ~imm});
        i_fetch.offer({OPC_ANDNI, 5'h07, 5'h03, r[15:0]}, 32'h0000_0100, a, ~a, pv, r[31:16]);
    endtask : andni

    // A refused branch encoding must raise illegal only: no PC load, no write-back; its stall is not checked.
    task automatic illegal_op(input logic [31:0] instr);
        notes.push_back({1'b1, 3'h1, ZERO_WORD});
        i_fetch.offer(instr, 32'h0000_0200, ZERO_WORD, PC_STEP, 1'b0, 16'h0000);
    endtask : illegal_op

    // Results are matched against notes in issue order; the stall length follows each branch.
    initial begin
        logic [35:0] n;
        int stall;
        forever begin
            @(posedge sys_clk);
            #2;
            if (pc_load === 1'b1 || wb.valid === 1'b1 || illegal === 1'b1) begin
                n = (notes.size() > 0) ? notes.pop_front() : 36'hf_ffff_ffff;
                check("wb valid", {31'h0, wb.valid}, {31'h0, n[35] & ~n[32]});
                check("illegal", {31'h0, illegal}, {31'h0, n[35] & n[32]});
                check("pc load", {31'h0, pc_load}, {31'h0, ~n[35]});
                if (n[35] && !n[32]) begin
                    check("wb data", wb.data, n[31:0]);
                    check("wb dest", {27'h0, wb.dest}, 32'h0000_0007);
                end else if (!n[35]) begin
                    check("pc target", pc_target, n[31:0]);
                    check("kill next", {31'h0, kill_next}, {31'h0, n[34]});
                    stall = 0;
                    while (busy === 1'b1 && stall < 4) begin
                        stall++;
                        @(posedge sys_clk);
                        #2;
                    end
                    check("stall cycles", stall, {30'h0, n[33:32]});
                end
            end
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        logic [31:0] vals[5];
        logic [3:0] conds[6];
        logic [31:0] x;
        vals = '{32'h0000_0000, 32'h0000_0001, 32'hffff_ffff, 32'h8000_0000, 32'h7fff_ffff};
        conds = '{COND_EQ, COND_NE, COND_LT, COND_LE, COND_GT, COND_GE};
        repeat (2) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        @(posedge sys_clk);
        foreach (conds[c]) begin
            foreach (vals[v]) begin
                for (int f = 0; f < 4; f++) begin
                    branch(f[0], f[1], conds[c], vals[v]);
                end
            end
        end
        andni(1'b0);
        andni(1'b1);
        illegal_op({OPC_BRC_IMM, 1'b0, 4'h9, 5'h03, 16'h0010});
        illegal_op({OPC_BRC_REG, 1'b1, COND_EQ, 5'h03, 5'h04, 11'h001});
        repeat (30) begin
            rnd(x);
            if (x[5]) begin
                andni(x[6]);
            end else begin
                branch(x[0], x[1], conds[x[4:2] % 6], x);
            end
        end
        i_fetch.release_bus();
        repeat (6) @(posedge sys_clk);
        check("pending notes", notes.size(), 32'h0);
        final_report();
    end
endmodule : tb_conditional_branch_unit
